/* File: cptg_gate.sv */
`timescale 1ns/1ps

// Summary of operation
// R1 - Separate CPU, transfer and DMA levels
// R2 - Gate off enables every transfer request
// R3 - Hold transfer request while CPU level higher
// R4 - Hold DMA channel while CPU level higher
// R5 - Channels at or above CPU keep running
// R6 - One transfer level for all sources
// R7 - Auto select mirrors CPU mask
// R8 - Manual select allows software writes
// R9 - Mode 0 maps single mask bit high
// R10 - Mode 2 copies three mask bits
// R11 - Clear takes effect after instruction ends
// R12 - Higher pending request wins clear conflict
// R13 - Late request does both transfer and exception
// R14 - Mask instruction blocks all interrupts next
// R15 - New mask bit valid two states later
// R16 - Three-state block and register write block
// R17 - Byte block move blocks all interrupts
// R18 - Word block move breaks after transfer cycle
// R19 - String move saves its own address
// R20 - Transfer access clears selected sources
// R21 - Software gives equal transfer and DMA levels
// R22 - Software reads flag back after clearing
// R23 - Software keeps CPU level not above transfers
// R24 - Unsigned compare every cycle
module cptg_gate
   import cptg_pkg::*;
#(
   parameter int DMA_CHANNELS = 4,
   parameter int SRC_COUNT    = 8
) (
   // Clock and reset.
   input  wire  logic                    clk_sys_in,
   input  wire  logic                    reset_in,
   // APB slave.
   input  wire  logic                    psel_in,
   input  wire  logic                    penable_in,
   input  wire  logic                    pwrite_in,
   input  wire  logic [7:0]              paddr_in,
   input  wire  logic [31:0]             pwdata_in,
   output logic       [31:0]             prdata_out,
   output logic                          pready_out,
   output logic                          pslverr_out,
   // CPU core mask and status.
   input  wire  cptg_mode_t              ctrl_mode_in,
   input  wire  logic                    ccr_mask_bit_in,
   input  wire  logic [2:0]              extended_mask_bits_in,
   input  wire  cptg_cpu_status_t        cpu_status_in,
   // Raw activation requests.
   input  wire  logic                    xfer_request_in,
   input  wire  logic [DMA_CHANNELS-1:0] dma_request_in,
   // Transfer side register accesses of designated sources.
   input  wire  logic [SRC_COUNT-1:0]    xfer_src_access_in,
   // Gated activations, CPU acceptance and source clears.
   output logic                          xfer_activate_out,
   output logic [DMA_CHANNELS-1:0]       dma_activate_out,
   output cptg_accept_t                  accept_out,
   output logic [SRC_COUNT-1:0]          src_clear_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // State.
   typedef struct packed {
      logic [2:0]                    cpu_level;
      logic [2:0]                    xfer_level;
      logic                          gate_en;
      logic                          auto_sel;
      logic [DMA_CHANNELS-1:0][2:0]  dma_level;
      logic [SRC_COUNT-1:0]          src_clear_sel;
      logic [1:0]                    block_cnt;
      logic [1:0]                    effect_cnt;
      logic [2:0]                    mask_shadow;
      logic                          byte_move_busy;
      logic                          xfer_act;
      logic [DMA_CHANNELS-1:0]       dma_act;
      cptg_accept_t                  accept;
      logic [SRC_COUNT-1:0]          src_clear;
      logic [31:0]                   rdata;
      logic                          rd_done;
   } cptg_state_t;

   cptg_state_t state_reg;
   cptg_state_t state_next;

   // Returns one when the CPU level holds a request at the given level.
   function automatic logic held_by_cpu(input logic [2:0] cpu_lvl,
                                        input logic [2:0] req_lvl,
                                        input logic       gate);
      held_by_cpu = gate && (cpu_lvl > req_lvl);  // see R24
   endfunction

   logic       access;
   logic       wr;
   logic       reg_write_active;
   logic [2:0] mask_now;

   assign access           = psel_in && penable_in;
   assign wr               = access && pwrite_in;
   assign reg_write_active = psel_in && pwrite_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.
   always_comb begin
      state_next = state_reg;

      // Live mask as the CPU would present it.
      if (ctrl_mode_in == CTRL_MODE_0) begin
         mask_now = {ccr_mask_bit_in, 2'b00};  // see R9
      end else begin
         mask_now = extended_mask_bits_in;  // see R10
      end

      // The mirror goes first so that a write with the select bit clear takes the field.
      if (state_reg.auto_sel) begin
         state_next.cpu_level = state_reg.mask_shadow;  // see R7
      end

      // Register writes land on the APB access edge.
      if (wr) begin
         unique case (paddr_in)
            PRIO_CTRL_OFFSET: begin
               if (!pwdata_in[AUTO_SEL_BIT]) begin
                  state_next.cpu_level = pwdata_in[CPU_LEVEL_LSB +: 3];  // see R8
               end
               state_next.xfer_level = pwdata_in[XFER_LEVEL_LSB +: 3];  // see R1, R6
               state_next.gate_en    = pwdata_in[GATE_EN_BIT];
               state_next.auto_sel   = pwdata_in[AUTO_SEL_BIT];
            end
            DMA_LEVEL_OFFSET: begin
               for (int i = 0; i < DMA_CHANNELS; i++) begin
                  state_next.dma_level[i] = pwdata_in[i*DMA_FIELD_STRIDE +: 3];  // see R1
               end
            end
            SRC_CLEAR_OFFSET: begin
               state_next.src_clear_sel = pwdata_in[SRC_COUNT-1:0];
            end
            default: begin
            end
         endcase
      end

      // A mask update starts the acceptance block and the effect delay.
      if (cpu_status_in.mask_op_done) begin
         state_next.block_cnt  = 2'(MASK_BLOCK_STATES);  // see R14, R16
         state_next.effect_cnt = 2'(MASK_EFFECT_DELAY);  // see R15
      end else begin
         if (state_reg.block_cnt != 2'h0) begin
            state_next.block_cnt = state_reg.block_cnt - 2'h1;
         end
         if (state_reg.effect_cnt != 2'h0) begin
            state_next.effect_cnt = state_reg.effect_cnt - 2'h1;
         end
      end

      // The mirrored mask only follows once the effect delay has run out.
      if (state_reg.effect_cnt == 2'h0 && !cpu_status_in.mask_op_done) begin
         state_next.mask_shadow = mask_now;  // see R15
      end

      state_next.byte_move_busy = cpu_status_in.block_move_byte;  // see R17

      // Gating, recomputed every cycle from the registered levels.
      state_next.xfer_act = xfer_request_in &&
         !held_by_cpu(state_reg.cpu_level, state_reg.xfer_level,
                      state_reg.gate_en);  // see R2, R3, R13
      for (int i = 0; i < DMA_CHANNELS; i++) begin
         state_next.dma_act[i] = dma_request_in[i] &&
            !held_by_cpu(state_reg.cpu_level, state_reg.dma_level[i],
                         state_reg.gate_en);  // see R4, R5
      end

      // Acceptance: the CPU core samples it only at instruction or cycle ends,
      // so enables cleared inside an instruction still let it finish first.
      state_next.accept.nmi_allowed = !cpu_status_in.mask_op_done &&
         (state_reg.block_cnt == 2'h0) &&
         !cpu_status_in.block_move_byte;  // see R14, R17
      state_next.accept.accept_allowed = state_next.accept.nmi_allowed &&
         !reg_write_active &&
         (cpu_status_in.instr_end ||
          (cpu_status_in.block_move_word && cpu_status_in.xfer_cycle_end) ||
          (cpu_status_in.string_move && cpu_status_in.xfer_cycle_end));  // see R11, R12, R16, R18
      state_next.accept.save_current_pc = cpu_status_in.string_move &&
         cpu_status_in.xfer_cycle_end;  // see R19

      state_next.src_clear = xfer_src_access_in & state_reg.src_clear_sel;  // see R20

      // Read data is registered, so reads answer one cycle into the access phase.
      state_next.rd_done = access && !pwrite_in && !state_reg.rd_done;
      state_next.rdata   = UNMAPPED_READ;
      if (access && !pwrite_in) begin
         unique case (paddr_in)
            PRIO_CTRL_OFFSET: begin
               state_next.rdata[CPU_LEVEL_LSB +: 3]  = state_reg.cpu_level;
               state_next.rdata[XFER_LEVEL_LSB +: 3] = state_reg.xfer_level;
               state_next.rdata[GATE_EN_BIT]         = state_reg.gate_en;
               state_next.rdata[AUTO_SEL_BIT]        = state_reg.auto_sel;
            end
            DMA_LEVEL_OFFSET: begin
               for (int i = 0; i < DMA_CHANNELS; i++) begin
                  state_next.rdata[i*DMA_FIELD_STRIDE +: 3] = state_reg.dma_level[i];
               end
            end
            STATUS_OFFSET: begin
               state_next.rdata[0]                = state_reg.xfer_act;
               state_next.rdata[1]                = state_reg.accept.accept_allowed;
               state_next.rdata[8 +: DMA_CHANNELS] = state_reg.dma_act;
            end
            SRC_CLEAR_OFFSET: begin
               state_next.rdata[SRC_COUNT-1:0] = state_reg.src_clear_sel;
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         state_reg            <= '0;
         state_reg.cpu_level  <= LEVEL_RESET;
         state_reg.xfer_level <= LEVEL_RESET;
         state_reg.gate_en    <= GATE_EN_RESET;
         state_reg.auto_sel   <= AUTO_SEL_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign xfer_activate_out = state_reg.xfer_act;
   assign dma_activate_out  = state_reg.dma_act;
   assign accept_out        = state_reg.accept;
   assign src_clear_out     = state_reg.src_clear;

   assign prdata_out  = state_reg.rdata;
   assign pready_out  = pwrite_in ? access : state_reg.rd_done;
   assign pslverr_out = 1'b0;

endmodule

/* File: cptg_pkg.sv */
package cptg_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map, one aligned 32-bit word each.
   localparam logic [7:0] PRIO_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] DMA_LEVEL_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET    = 8'h08;
   localparam logic [7:0] SRC_CLEAR_OFFSET = 8'h0C;

   // Field positions inside priority_control_reg.
   localparam int CPU_LEVEL_LSB  = 0;
   localparam int XFER_LEVEL_LSB = 4;
   localparam int GATE_EN_BIT    = 8;
   localparam int AUTO_SEL_BIT   = 9;

   // Field spacing of the per-channel DMA levels.
   localparam int DMA_FIELD_STRIDE = 4;

   // Values after reset.
   localparam logic [2:0] LEVEL_RESET    = 3'h0;
   localparam logic       GATE_EN_RESET  = 1'h0;
   localparam logic       AUTO_SEL_RESET = 1'h0;

   // Acceptance block and mask effect delay after a mask update, in system clock states.
   localparam int MASK_BLOCK_STATES = 3;
   localparam int MASK_EFFECT_DELAY = 2;

   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt control modes.
   typedef enum logic {
      CTRL_MODE_0,
      CTRL_MODE_2
   } cptg_mode_t;

   // Per-cycle CPU execution status.
   typedef struct packed {
      logic       mask_op_done;
      logic       block_move_byte;
      logic       block_move_word;
      logic       xfer_cycle_end;
      logic       string_move;
      logic       instr_end;
   } cptg_cpu_status_t;

   // Acceptance decision toward the CPU core.
   typedef struct packed {
      logic       accept_allowed;
      logic       nmi_allowed;
      logic       save_current_pc;
   } cptg_accept_t;

endpackage

/* File: cptg_gate_assertions.sv */
`timescale 1ns/1ps
module cptg_gate_chk
   import cptg_pkg::*;
#(
   parameter int DMA_CHANNELS = 4,
   parameter int SRC_COUNT    = 8
) (
   // Clock, reset and bus.
   input wire logic                    clk_sys_in,
   input wire logic                    reset_in,
   input wire logic                    psel_in,
   input wire logic                    pwrite_in,
   // CPU status, requests and source accesses.
   input wire cptg_cpu_status_t        cpu_status_in,
   input wire logic                    xfer_request_in,
   input wire logic [DMA_CHANNELS-1:0] dma_request_in,
   input wire logic [SRC_COUNT-1:0]    xfer_src_access_in,
   // Gated outputs.
   input wire logic                    xfer_activate_out,
   input wire logic [DMA_CHANNELS-1:0] dma_activate_out,
   input wire cptg_accept_t            accept_out,
   input wire logic [SRC_COUNT-1:0]    src_clear_out
);
   ////////////////////////////////////////
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   chk_xfer_needs_req: assert property (xfer_activate_out |-> $past(xfer_request_in))
      else $error("transfer activation without request");
   chk_dma_needs_req: assert property ((dma_activate_out & ~$past(dma_request_in)) == '0)
      else $error("dma activation without request");
   chk_clear_needs_acc: assert property ((src_clear_out & ~$past(xfer_src_access_in)) == '0)
      else $error("source clear without access");
   chk_mask_block_three: assert property (cpu_status_in.mask_op_done |=>
      !accept_out.accept_allowed [*3]) else $error("accept inside mask block");
   chk_mask_nmi_block: assert property (cpu_status_in.mask_op_done |=>
      !accept_out.nmi_allowed) else $error("nmi accepted after mask op");
   chk_byte_move_block: assert property (cpu_status_in.block_move_byte |=>
      !accept_out.accept_allowed && !accept_out.nmi_allowed) else $error("accept in byte move");
   chk_write_blocks: assert property (psel_in && pwrite_in |=>
      !accept_out.accept_allowed) else $error("accept during register write");
   chk_accept_cause: assert property (accept_out.accept_allowed |->
      $past(cpu_status_in.instr_end || ((cpu_status_in.block_move_word ||
      cpu_status_in.string_move) && cpu_status_in.xfer_cycle_end)))
      else $error("accept without instruction or cycle end");
   chk_save_own_pc: assert property (accept_out.save_current_pc |->
      $past(cpu_status_in.string_move)) else $error("own address saved outside string move");
   cover property (xfer_activate_out);
   cover property (accept_out.save_current_pc);
   cover property (src_clear_out != '0);
endmodule
bind cptg_gate cptg_gate_chk #(.DMA_CHANNELS(DMA_CHANNELS), .SRC_COUNT(SRC_COUNT)) u_chk (
   .clk_sys_in, .reset_in, .psel_in, .pwrite_in, .cpu_status_in, .xfer_request_in,
   .dma_request_in, .xfer_src_access_in, .xfer_activate_out, .dma_activate_out,
   .accept_out, .src_clear_out);

/* File: cptg_req_model.sv */
`timescale 1ns/1ps
module cptg_req_model
   import cptg_pkg::*;
#(
   parameter int N = 5
) (
   // Clock and reset.
   input  wire logic         clk_sys_in,
   input  wire logic         reset_in,
   // Bench command and gated answer.
   input  wire logic [N-1:0] go_in,
   input  wire logic [N-1:0] act_in,
   // Raw activation requests.
   output logic      [N-1:0] req_out
);
   // A request waits while it is held and drops once it has been activated.
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         req_out <= '0;
      end else begin
         req_out <= (req_out & ~act_in) | go_in;
      end
   end
endmodule

/* File: cptg_gate_tb.sv */
`timescale 1ns/1ps
module cptg_gate_tb;
   import cptg_pkg::*;
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic psel, penable, pwrite, pready, ccr_bit, perr;
   logic [7:0] paddr, acc, clr;
   logic [31:0] pwdata, prdata;
   logic [31:0] seed = 32'h2B50;
   logic [2:0] ext_bits;
   logic [4:0] go, req, act;
   cptg_mode_t mode;
   cptg_cpu_status_t st;
   cptg_accept_t acpt;
   int n_mismatch = 0;
   int compares = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   cptg_gate dut (.clk_sys_in, .reset_in, .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(perr), .ctrl_mode_in(mode), .ccr_mask_bit_in(ccr_bit),
      .extended_mask_bits_in(ext_bits), .cpu_status_in(st), .xfer_request_in(req[4]),
      .dma_request_in(req[3:0]), .xfer_src_access_in(acc), .xfer_activate_out(act[4]),
      .dma_activate_out(act[3:0]), .accept_out(acpt), .src_clear_out(clr));
   cptg_req_model #(.N(5)) partner (.clk_sys_in, .reset_in, .go_in(go), .act_in(act),
      .req_out(req));
   ////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(string what, logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      @(posedge clk_sys_in);
      while (pready !== 1'b1) @(posedge clk_sys_in);
      q = prdata;
      check("bus error", 32'(perr), 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic gate_run(cptg_mode_t m, logic c, logic [2:0] e, logic gate, logic auto,
                           logic [2:0] cpu, logic [2:0] xl, logic [31:0] dr);
      logic [31:0] q;
      logic [4:0] seen, exp;
      logic [2:0] lv;
      mode <= m;
      ccr_bit <= c;
      ext_bits <= e;
      lv = !auto ? cpu : (m == CTRL_MODE_0) ? {c, 2'b00} : e;
      apb(1'b1, PRIO_CTRL_OFFSET, {22'h0, auto, gate, 1'b0, xl, 1'b0, cpu}, q);
      apb(1'b1, DMA_LEVEL_OFFSET, dr, q);
      repeat (3) @(posedge clk_sys_in);
      apb(1'b0, PRIO_CTRL_OFFSET, 32'h0, q);
      check("cpu level", q & 32'h7, 32'(lv));
      seen = '0;
      go <= 5'h1F;
      @(posedge clk_sys_in);
      go <= 5'h00;
      repeat (5) begin
         @(posedge clk_sys_in);
         seen |= act;
      end
      exp[4] = !(gate && lv > xl);
      for (int i = 0; i < 4; i++) begin
         exp[i] = !(gate && lv > dr[4*i +: 3]);
      end
      check("activations", 32'(seen), 32'(exp));
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      logic [31:0] q, r;
      logic [5:0] sv [5] = '{6'h01, 6'h11, 6'h0C, 6'h06, 6'h00};
      logic [2:0] ev [5] = '{3'h6, 3'h0, 3'h6, 3'h7, 3'h2};
      {psel, penable, pwrite, ccr_bit, paddr, pwdata, ext_bits, go, acc} = '0;
      mode = CTRL_MODE_0;
      st = '0;
      repeat (3) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      apb(1'b0, PRIO_CTRL_OFFSET, 32'h0, q);
      check("prio reset", q, 32'h0);
      apb(1'b0, 8'h10, 32'h0, q);
      check("unmapped read", q, UNMAPPED_READ);
      gate_run(CTRL_MODE_2, 1'b0, 3'h0, 1'b1, 1'b0, 3'h5, 3'h3, 32'h5555);
      gate_run(CTRL_MODE_2, 1'b0, 3'h0, 1'b1, 1'b0, 3'h6, 3'h3, 32'h5555);
      gate_run(CTRL_MODE_0, 1'b0, 3'h0, 1'b0, 1'b0, 3'h7, 3'h0, 32'h0000);
      gate_run(CTRL_MODE_0, 1'b1, 3'h0, 1'b1, 1'b1, 3'h0, 3'h3, 32'h0004);
      gate_run(CTRL_MODE_2, 1'b0, 3'h5, 1'b1, 1'b1, 3'h7, 3'h5, 32'h4566);
      gate_run(CTRL_MODE_2, 1'b0, 3'h0, 1'b1, 1'b0, 3'h2, 3'h4, 32'h4444);
      for (int k = 0; k < 30; k++) begin
         r = rnd();
         gate_run(cptg_mode_t'(r[0]), r[1], r[4:2], r[5], r[6], r[9:7], r[12:10],
                  rnd() & 32'h7777);
      end
      $display("test gating done");
      for (int k = 0; k < 5; k++) begin
         st <= sv[k];
         repeat (2) @(posedge clk_sys_in);
         check("acceptance", 32'(acpt), 32'(ev[k]));
      end
      st <= 6'h21;
      @(posedge clk_sys_in);
      st <= 6'h01;
      repeat (6) @(posedge clk_sys_in);
      #1;
      check("accept after block", 32'(acpt), 32'h6);
      apb(1'b0, STATUS_OFFSET, 32'h0, q);
      check("status", q, 32'h0000_0002);
      $display("test acceptance done");
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         apb(1'b1, SRC_CLEAR_OFFSET, {24'h0, r[7:0]}, q);
         acc <= r[15:8];
         @(posedge clk_sys_in);
         acc <= 8'h00;
         #1;
         check("source clear", 32'(clr), 32'(r[7:0] & r[15:8]));
         apb(1'b0, SRC_CLEAR_OFFSET, 32'h0, q);
         check("clear select", q, 32'(r[7:0]));
      end
      $display("test source clear done");
      give_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk_sys_in);
      n_mismatch++;
      give_verdict();
   end
endmodule
